// ==== shared/eewr_pkg.sv ====
// Constants and carrier types of the serial EEPROM write-side command logic
package eewr_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS          = 20;
	localparam int PROGRAM_CYCLE_TIME_NS  = 5000000;
	// Longest time, so the division rounds down
	localparam int PROGRAM_CYCLES         = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;
	localparam int CNT_W                  = 32;

	// ---------------------------------------------------------------
	// Address and array geometry
	// ---------------------------------------------------------------
	localparam int MAX_ADDR_W             = 13;
	localparam int PAGE_BITS              = 5;
	localparam int PAGE_BYTES             = 32;
	localparam int BYTE_BITS              = 8;
	localparam int BIT_CNT_W              = 4;
	localparam logic [BIT_CNT_W-1:0] ACK_SLOT = 4'h8;
	localparam logic [MAX_ADDR_W-1:0] RESET_ADDR = 13'h0000;

	// ---------------------------------------------------------------
	// Device address byte fields
	// ---------------------------------------------------------------
	localparam logic [3:0] TYPE_ID        = 4'ha;
	localparam int TYPE_MSB               = 7;
	localparam int TYPE_LSB               = 4;
	localparam int SEL_MSB                = 3;
	localparam int SEL_LSB                = 1;
	localparam int SEL_W                  = 3;
	localparam int RW_BIT                 = 0;
	localparam int HI_MSB                 = 4;

	// ---------------------------------------------------------------
	// Synchronised pin vector layout
	// ---------------------------------------------------------------
	localparam int SYNC_W                 = 6;
	localparam int SYNC_SCL               = 0;
	localparam int SYNC_SDA               = 1;
	localparam int SYNC_WP                = 2;
	localparam int SYNC_SEL_LSB           = 3;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_DEV     = 3'h1,
		ST_ADDR_HI = 3'h3,
		ST_ADDR_LO = 3'h2,
		ST_DATA    = 3'h6
	} eewr_state_t;

	typedef struct packed {
		logic [MAX_ADDR_W-1:0] addr;
		logic [BYTE_BITS-1:0]  data;
	} eewr_word_t;

	localparam int WORD_W                 = $bits(eewr_word_t);

endpackage

// ==== hdl/eewr_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module eewr_sync #(
	parameter int           W    = 1,
	// Reset level of every stage, the idle level of each pin
	parameter logic [W-1:0] IDLE = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Pins and filtered levels
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} eewr_sync_state_t;

	eewr_sync_state_t r_reg;
	eewr_sync_state_t r_next;

	always_comb
	begin
		r_next    = r_reg;
		r_next.s1 = pin;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		// A bit moves only once two later stages agree
		for (int i = 0; i < W; i++)
		begin
			if (r_reg.s2[i] == r_reg.s3[i])
				r_next.q[i] = r_reg.s3[i];
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			r_reg <= {4{IDLE}};
		else
			r_reg <= r_next;
	end

	assign level = r_reg.q;

endmodule // eewr_sync

// ==== hdl/eewr_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ns
module eewr_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Discard all content
	input  wire logic             flush,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW:0]                 wp;
		logic [PW:0]                 rp;
	} eewr_fifo_state_t;

	eewr_fifo_state_t r_reg;
	eewr_fifo_state_t r_next;
	logic             full;
	logic             empty;

	assign empty     = (r_reg.wp == r_reg.rp);
	assign full      = (r_reg.wp[PW-1:0] == r_reg.rp[PW-1:0]) && (r_reg.wp[PW] != r_reg.rp[PW]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = r_reg.mem[r_reg.rp[PW-1:0]];

	always_comb
	begin
		r_next = r_reg;
		if (in_valid && !full)
		begin
			r_next.mem[r_reg.wp[PW-1:0]] = in_data;
			r_next.wp = r_reg.wp + 1'b1;
		end
		if (out_ready && !empty)
			r_next.rp = r_reg.rp + 1'b1;
		if (flush)
		begin
			r_next.wp = '0;
			r_next.rp = '0;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

endmodule // eewr_fifo

// ==== hdl/eewr_top.sv ====
// Serial EEPROM target: addressing, page write buffering, program timing
`timescale 1ns/1ns
module eewr_top
	import eewr_pkg::*;
#(
	parameter int ADDR_W         = 13,
	parameter int PROGRAM_CYCLES = eewr_pkg::PROGRAM_CYCLES,
	parameter int FIFO_DEPTH     = eewr_pkg::PAGE_BYTES
) (
	// Clock and reset
	input  wire logic                             clk,
	input  wire logic                             reset,
	// Two-wire bus
	input  wire logic                             scl_in,
	input  wire logic                             sda_in,
	output logic                                  sda_out,
	output logic                                  sda_oe_n,
	// Strap and protect pins
	input  wire logic                             chip_select_strap_0,
	input  wire logic                             chip_select_strap_1,
	input  wire logic                             chip_select_strap_2,
	input  wire logic                             write_protect,
	// Array write port
	output logic                                  mem_wr_valid,
	input  wire logic                             mem_wr_ready,
	output logic      [eewr_pkg::MAX_ADDR_W-1:0]  mem_wr_addr,
	output logic      [eewr_pkg::BYTE_BITS-1:0]   mem_wr_data,
	// Status
	output logic                                  program_busy
);

	import eewr_pkg::*;

	// ---------------------------------------------------------------
	// Constants
	// ---------------------------------------------------------------
	localparam logic [CNT_W-1:0] LAST_CYCLE = CNT_W'(PROGRAM_CYCLES - 1);
	// Smaller density ignores the address bits of the first byte above ADDR_W
	localparam logic [HI_MSB:0]  HI_MASK    = (HI_MSB+1)'((1 << (ADDR_W - BYTE_BITS)) - 1);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic                  scl_q;
		logic                  sda_q;
		eewr_state_t           st;
		eewr_state_t           nxt;
		logic [BIT_CNT_W-1:0]  bits;
		logic [BYTE_BITS-1:0]  shift;
		logic                  ack_phase;
		logic                  acked;
		logic                  got_data;
		logic                  busy;
		logic [CNT_W-1:0]      cnt;
		logic [MAX_ADDR_W-1:0] addr;
		logic                  sda_out;
		logic                  sda_oe_n;
		logic                  wr_valid;
		eewr_word_t            wr;
	} eewr_top_state_t;

	eewr_top_state_t r_reg;
	eewr_top_state_t r_next;

	logic [SYNC_W-1:0] pins;
	logic              fifo_push;
	logic              fifo_in_ready;
	eewr_word_t        fifo_in_word;
	logic              fifo_out_valid;
	logic              fifo_pop;
	eewr_word_t        fifo_out_word;
	logic              fifo_flush;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic dev_match(
		input logic [BYTE_BITS-1:0] b,
		input logic [SEL_W-1:0]     sel
	);
		return (b[TYPE_MSB:TYPE_LSB] == TYPE_ID) && (b[SEL_MSB:SEL_LSB] == sel);
	endfunction

	function automatic logic [MAX_ADDR_W-1:0] page_next(
		input logic [MAX_ADDR_W-1:0] a
	);
		return {a[MAX_ADDR_W-1:PAGE_BITS], a[PAGE_BITS-1:0] + 1'b1};
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Unconnected straps and protect are held low by the pad itself
	// floating strap zero
	eewr_sync #(
		.W    (SYNC_W),
		.IDLE ({{SEL_W{1'b0}}, 1'b0, 1'b1, 1'b1})
	) u_sync (
		.clk   (clk),
		.reset (reset),
		.pin   ({chip_select_strap_2, chip_select_strap_1, chip_select_strap_0,
		         write_protect, sda_in, scl_in}),
		.level (pins)
	);

	// ---------------------------------------------------------------
	// Page buffer
	// ---------------------------------------------------------------
	eewr_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.flush     (fifo_flush),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_word),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_word)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic scl;
		logic sda;
		logic start_cond;
		logic stop_cond;
		logic scl_rise;
		logic scl_fall;
		logic ok;
		scl          = pins[SYNC_SCL];
		sda          = pins[SYNC_SDA];
		ok           = 1'b0;
		r_next       = r_reg;
		fifo_push    = 1'b0;
		fifo_flush   = 1'b0;
		fifo_in_word = '{addr: r_reg.addr, data: r_reg.shift};
		r_next.scl_q = scl;
		r_next.sda_q = sda;
		start_cond   = scl && r_reg.scl_q && r_reg.sda_q && !sda;
		stop_cond    = scl && r_reg.scl_q && !r_reg.sda_q && sda;
		scl_rise     = scl && !r_reg.scl_q;
		scl_fall     = !scl && r_reg.scl_q;

		// Array port drains the buffer only during a programming cycle
		if (r_reg.wr_valid && mem_wr_ready)
			r_next.wr_valid = 1'b0;
		fifo_pop = r_reg.busy && fifo_out_valid && (!r_reg.wr_valid || mem_wr_ready);
		if (fifo_pop)
		begin
			r_next.wr_valid = 1'b1;
			r_next.wr       = fifo_out_word;
		end

		if (r_reg.busy)
		begin
			if (r_reg.cnt != LAST_CYCLE)
				r_next.cnt = r_reg.cnt + 1'b1;
			else if (!fifo_out_valid && !r_next.wr_valid)
				r_next.busy = 1'b0;
		end

		if (r_reg.busy)
		begin
			r_next.st        = ST_IDLE;
			r_next.ack_phase = 1'b0;
			r_next.sda_oe_n  = 1'b1;
		end
		else if (start_cond)
		begin
			fifo_flush       = r_reg.got_data;
			r_next.got_data  = 1'b0;
			r_next.st        = ST_DEV;
			r_next.bits      = '0;
			r_next.ack_phase = 1'b0;
			r_next.sda_oe_n  = 1'b1;
		end
		else if (stop_cond)
		begin
			if (r_reg.got_data)
			begin
				if (pins[SYNC_WP])
					fifo_flush = 1'b1;
				else
				begin
					r_next.busy = 1'b1;
					r_next.cnt  = '0;
				end
			end
			r_next.got_data  = 1'b0;
			r_next.st        = ST_IDLE;
			r_next.ack_phase = 1'b0;
			r_next.sda_oe_n  = 1'b1;
		end
		else if (r_reg.st != ST_IDLE)
		begin
			if (scl_rise && !r_reg.ack_phase && r_reg.bits != ACK_SLOT)
			begin
				r_next.shift = {r_reg.shift[BYTE_BITS-2:0], sda};
				r_next.bits  = r_reg.bits + 1'b1;
			end
			if (scl_fall && r_reg.ack_phase)
			begin
				// Release after the ninth clock
				r_next.ack_phase = 1'b0;
				r_next.bits      = '0;
				r_next.sda_oe_n  = 1'b1;
				r_next.st        = r_reg.acked ? r_reg.nxt : ST_IDLE;
			end
			else if (scl_fall && r_reg.bits == ACK_SLOT)
			begin
				unique case (r_reg.st)
					ST_DEV:
					begin
						ok = dev_match(r_reg.shift, pins[SYNC_SEL_LSB +: SEL_W]);
						// direction bit
						// Reads stop after the device address acknowledge here
						r_next.nxt = r_reg.shift[RW_BIT] ? ST_IDLE : ST_ADDR_HI;
					end
					ST_ADDR_HI:
					begin
						ok          = 1'b1;
						r_next.addr = {r_reg.shift[HI_MSB:0] & HI_MASK, r_reg.addr[BYTE_BITS-1:0]};
						r_next.nxt  = ST_ADDR_LO;
					end
					ST_ADDR_LO:
					begin
						ok          = 1'b1;
						r_next.addr = {r_reg.addr[MAX_ADDR_W-1:BYTE_BITS], r_reg.shift};
						r_next.nxt  = ST_DATA;
					end
					ST_DATA:
					begin
						// buffer up to a page
						// A full buffer refuses the byte with a nack
						ok = fifo_in_ready;
						if (fifo_in_ready)
						begin
							fifo_push       = 1'b1;
							r_next.got_data = 1'b1;
							r_next.addr     = page_next(r_reg.addr);
						end
						r_next.nxt = ST_DATA;
					end
					default:
					begin
						ok         = 1'b0;
						r_next.nxt = ST_IDLE;
					end
				endcase
				r_next.ack_phase = 1'b1;
				r_next.acked     = ok;
				r_next.sda_oe_n  = !ok;
			end
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			r_reg          <= '0;
			r_reg.scl_q    <= 1'b1;
			r_reg.sda_q    <= 1'b1;
			r_reg.st       <= ST_IDLE;
			r_reg.nxt      <= ST_IDLE;
			r_reg.addr     <= RESET_ADDR;
			r_reg.sda_out  <= 1'b0;
			r_reg.sda_oe_n <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign sda_out      = r_reg.sda_out;
	assign sda_oe_n     = r_reg.sda_oe_n;
	assign mem_wr_valid = r_reg.wr_valid;
	assign mem_wr_addr  = r_reg.wr.addr;
	assign mem_wr_data  = r_reg.wr.data;
	assign program_busy = r_reg.busy;

endmodule // eewr_top

// ==== tb/eewr_master_model.sv ====
// Bus master model driving the two-wire lines for the bench
`timescale 1ns/1ns
module eewr_master_model (
	// Clock
	input  wire logic clk,
	// Two-wire lines, data as open drain
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Eight clocks per phase keep edges clear of the pin filter
	task automatic half();
		repeat (8) @(negedge clk);
	endtask

	task automatic start();
		sda_low = 1'b0;
		scl = 1'b1;
		half();
		sda_low = 1'b1;
		half();
		scl = 1'b0;
		half();
	endtask

	task automatic stop();
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask

	task automatic wr(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_low = !b[i];
			half();
			scl = 1'b1;
			half();
			scl = 1'b0;
			half();
		end
		sda_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		ack = (sda === 1'b0);
		scl = 1'b0;
		half();
	endtask
endmodule // eewr_master_model

// ==== tb/eewr_top_sva.sv ====
// Port checker for the serial EEPROM write-side target
`timescale 1ns/1ns
module eewr_top_sva
	import eewr_pkg::*;
#(
	parameter int ADDR_W         = 13,
	parameter int PROGRAM_CYCLES = 400,
	parameter int FIFO_DEPTH     = 32
) (
	// Clock and reset
	input wire logic                            clk,
	input wire logic                            reset,
	// Bus and pins
	input wire logic                            scl_in,
	input wire logic                            sda_in,
	input wire logic                            sda_out,
	input wire logic                            sda_oe_n,
	input wire logic                            chip_select_strap_0,
	input wire logic                            chip_select_strap_1,
	input wire logic                            chip_select_strap_2,
	input wire logic                            write_protect,
	// Array port and status
	input wire logic                            mem_wr_valid,
	input wire logic                            mem_wr_ready,
	input wire logic [eewr_pkg::MAX_ADDR_W-1:0] mem_wr_addr,
	input wire logic [eewr_pkg::BYTE_BITS-1:0]  mem_wr_data,
	input wire logic                            program_busy
);
	logic [CNT_W-1:0]      busy_cnt;
	logic [MAX_ADDR_W-1:0] prev_addr;
	logic                  have_prev;
	wire logic             take;
	assign take = mem_wr_valid && mem_wr_ready;

	// Tracks words of one cycle so the page step is checked within it only
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			busy_cnt  <= '0;
			have_prev <= 1'b0;
			prev_addr <= '0;
		end
		else
		begin
			busy_cnt  <= program_busy ? busy_cnt + 1'b1 : '0;
			have_prev <= program_busy && (have_prev || take);
			if (take)
				prev_addr <= mem_wr_addr;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_sda_drive_low: assert property (sda_out == 1'b0)
		else $error("sda drive value not low");
	a_ack_edge_low: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("ack changed with clock high");
	a_ack_spans_high: assert property ($rose(scl_in) && !sda_oe_n |=> !sda_oe_n [*6])
		else $error("ack dropped in clock high");
	a_busy_no_ack: assert property (program_busy |-> sda_oe_n)
		else $error("ack given while busy");
	a_busy_after_stop: assert property ($rose(program_busy) |-> scl_in && sda_in)
		else $error("busy began outside a stop");
	a_wp_blocks: assert property ($rose(program_busy) |-> !write_protect)
		else $error("busy began while protected");
	a_word_holds: assert property (mem_wr_valid && !mem_wr_ready |=>
		mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
		else $error("array word changed before taken");
	a_write_in_busy: assert property (mem_wr_valid |-> program_busy)
		else $error("array write outside busy");
	a_busy_length: assert property ($fell(program_busy) |-> busy_cnt >= PROGRAM_CYCLES)
		else $error("busy ended early");
	a_page_step: assert property (take && have_prev |->
		mem_wr_addr == {prev_addr[12:5], prev_addr[4:0] + 5'h1})
		else $error("address left page order");

	c_ack: cover property ($fell(sda_oe_n));
	c_busy: cover property ($rose(program_busy));
	c_stall: cover property (mem_wr_valid && !mem_wr_ready ##1 take);
endmodule // eewr_top_sva

bind eewr_top eewr_top_sva #(.ADDR_W(ADDR_W), .PROGRAM_CYCLES(PROGRAM_CYCLES),
	.FIFO_DEPTH(FIFO_DEPTH)) u_sva (.clk(clk), .reset(reset), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.chip_select_strap_0(chip_select_strap_0), .chip_select_strap_1(chip_select_strap_1),
	.chip_select_strap_2(chip_select_strap_2), .write_protect(write_protect),
	.mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
	.mem_wr_data(mem_wr_data), .program_busy(program_busy));

// ==== tb/tb.sv ====
// Self-checking bench for the serial EEPROM write-side target
`timescale 1ns/1ns
module tb;
	import eewr_pkg::*;
	localparam int PCYC = 400;
	logic                  clk = 1'b0;
	logic                  reset = 1'b1;
	logic                  write_protect = 1'b0;
	logic                  mem_wr_ready = 1'b0;
	logic [2:0]            strap = 3'h0;
	logic                  sda_oe_n, sda_out, mem_wr_valid, program_busy, scl, sda_low, sda, ack;
	logic [MAX_ADDR_W-1:0] mem_wr_addr;
	logic [BYTE_BITS-1:0]  mem_wr_data;
	logic [7:0]            dev;
	int                    fails = 0, checks_done = 0, cyc = 0;
	eewr_word_t            got_q[$];

	always #10 clk = ~clk;
	// Open-drain wire with pull-up
	assign sda = (sda_oe_n === 1'b0 || sda_low) ? 1'b0 : 1'b1;

	eewr_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	eewr_top #(.PROGRAM_CYCLES(PCYC)) dut (.clk(clk), .reset(reset), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.chip_select_strap_0(strap[0]), .chip_select_strap_1(strap[1]),
		.chip_select_strap_2(strap[2]), .write_protect(write_protect),
		.mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data), .program_busy(program_busy));

	// Random stalls on the array side
	always @(negedge clk)
		mem_wr_ready <= ($urandom % 3) != 0;

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (mem_wr_valid && mem_wr_ready)
			got_q.push_back(eewr_word_t'{mem_wr_addr, mem_wr_data});
		if (cyc == 90000)
		begin
			fails++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [12:0] page_addr(input logic [12:0] base, input int i);
		page_addr = {base[12:5], base[4:0] + 5'(i)};
	endfunction

	task automatic poll(input logic [7:0] b, input logic exp);
		m.start();
		m.wr(b, ack);
		chk(ack, exp);
		m.stop();
	endtask

	task automatic do_write(input logic [7:0] hi, lo, input int n, input logic wp);
		logic [7:0]  d[$];
		logic [12:0] base;
		int          k;
		base = {hi[4:0], lo};
		write_protect = wp;
		got_q.delete();
		m.start();
		m.wr(dev, ack);
		chk(ack, 1'b1);
		m.wr(hi, ack);
		chk(ack, 1'b1);
		m.wr(lo, ack);
		chk(ack, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			d.push_back(8'($urandom));
			m.wr(d[i], ack);
			chk(ack, i < PAGE_BYTES);
		end
		m.stop();
		repeat (20) @(negedge clk);
		chk(program_busy, !wp && n > 0);
		if (program_busy === 1'b1)
		begin
			poll(dev, 1'b0);
			// Protect raised mid-cycle must not cut the cycle short
			write_protect = 1'b1;
			for (k = 0; k < 4000 && program_busy === 1'b1; k++)
				@(negedge clk);
			write_protect = 1'b0;
		end
		poll(dev, 1'b1);
		chk(got_q.size(), wp ? 0 : (n > PAGE_BYTES ? PAGE_BYTES : n));
		foreach (got_q[i])
			chk(got_q[i], {page_addr(base, i), d[i]});
	endtask

	initial
	begin
		void'($urandom(78574));
		strap = 3'($urandom);
		dev = {TYPE_ID, strap, 1'b0};
		repeat (2) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		repeat (10) @(negedge clk);
		poll({4'h5, strap, 1'b0}, 1'b0);
		poll({TYPE_ID, ~strap, 1'b0}, 1'b0);
		poll({TYPE_ID, strap, 1'b1}, 1'b1);
		do_write(8'hff, 8'h3e, 1, 1'b0);
		do_write(8'($urandom), 8'h1e, 4, 1'b0);
		do_write(8'($urandom), 8'($urandom), 33, 1'b0);
		do_write(8'h01, 8'h00, 3, 1'b1);
		do_write(8'h02, 8'h40, 0, 1'b0);
		// start low enough to stay inside the page
		for (int r = 0; r < 3; r++)
			do_write(8'($urandom), 8'($urandom) & 8'hf7, 1 + $urandom % 8, 1'b0);
		// Repeated start after a data byte must discard it
		got_q.delete();
		m.start();
		m.wr(dev, ack);
		m.wr(8'h03, ack);
		m.wr(8'h10, ack);
		m.wr(8'h5a, ack);
		chk(ack, 1'b1);
		poll(dev, 1'b1);
		repeat (20) @(negedge clk);
		chk(program_busy, 1'b0);
		chk(got_q.size(), 0);
		print_verdict();
	end
endmodule // tb
